// >>> verilog/lcdpal_pkg.sv
/*
 Constants and types shared by the colour palette lookup stage: register
 offsets, field positions, reset values, palette entry layout and the
 frame fetch format codes. Assumes nothing of its surroundings.
*/
package lcdpal_pkg;

  // Bus and table geometry.
  localparam int unsigned LCDPAL_ADDR_W = 12;
  localparam int unsigned LCDPAL_DATA_W = 32;
  localparam int unsigned LCDPAL_ENTRIES = 256;
  localparam int unsigned LCDPAL_INDEX_W = 8;
  localparam int unsigned LCDPAL_ENTRY_W = 24;
  localparam int unsigned LCDPAL_STORE_W = 16;

  // Register offsets (byte addresses, one aligned word each) and the entry page code in address bits 11:10.
  localparam logic [11:0] LCDPAL_CTRL_OFF = 12'h000;
  localparam logic [11:0] LCDPAL_MODE_OFF = 12'h004;
  localparam logic [1:0] LCDPAL_ENTRY_PAGE = 2'h1;

  // Fields of the palette control register.
  localparam int unsigned LCDPAL_EN_BIT = 0;
  localparam int unsigned LCDPAL_STAT_BIT = 1;
  localparam int unsigned LCDPAL_FIT_BIT = 2;
  localparam logic LCDPAL_EN_RST = 1'h0;

  // Fields of the frame fetch mode register.
  localparam int unsigned LCDPAL_MONO_BIT = 0;
  localparam int unsigned LCDPAL_FMT_LSB = 1;
  localparam int unsigned LCDPAL_COL_LSB = 4;
  localparam int unsigned LCDPAL_BURST_LSB = 8;
  localparam logic LCDPAL_MONO_RST = 1'h0;
  localparam logic [2:0] LCDPAL_FMT_RST = 3'h0;
  localparam logic [1:0] LCDPAL_COL_RST = 2'h0;
  localparam logic [4:0] LCDPAL_BURST_RST = 5'h00;

  // Stored colour fields within a 24-bit entry.
  localparam int unsigned LCDPAL_RED_MSB = 23;
  localparam int unsigned LCDPAL_RED_LSB = 19;
  localparam int unsigned LCDPAL_GRN_MSB = 15;
  localparam int unsigned LCDPAL_GRN_LSB = 10;
  localparam int unsigned LCDPAL_BLU_MSB = 7;
  localparam int unsigned LCDPAL_BLU_LSB = 3;

  // Cycles the pixel pipe needs to drain before the table is handed over.
  localparam logic [1:0] LCDPAL_DRAIN_CYCLES = 2'h2;

  // Burst limits for the rotated 64x128 frame.
  localparam logic [4:0] LCDPAL_BURST_NONE = 5'h00;
  localparam logic [4:0] LCDPAL_BURST_8 = 5'h08;
  localparam logic [4:0] LCDPAL_BURST_16 = 5'h10;

  // Column address width codes of the SDRAM.
  localparam logic [1:0] LCDPAL_COL_8 = 2'h0;
  localparam logic [1:0] LCDPAL_COL_9 = 2'h1;

  // Pixel format codes held in the mode register.
  typedef enum logic [2:0] {
    LCDPAL_FMT_1BPP = 3'h0,
    LCDPAL_FMT_2BPP = 3'h1,
    LCDPAL_FMT_4BPP_PACKED = 3'h2,
    LCDPAL_FMT_4BPP_UNPACKED = 3'h3,
    LCDPAL_FMT_6BPP = 3'h4,
    LCDPAL_FMT_8BPP = 3'h5
  } lcdpal_fmt_t;

  // Palette access states.
  typedef enum logic [1:0] {
    LCDPAL_ST_NORMAL,
    LCDPAL_ST_DRAIN,
    LCDPAL_ST_SETTING
  } lcdpal_state_t;

endpackage

// >>> verilog/lcdpal_ram.sv
/*
 Palette table memory: one write port, one read port, registered read data.
 Assumes a single clock; contents are undefined after power-up.
*/
`timescale 1ns/100ps
module lcdpal_ram #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Refuse a depth the address cannot reach.
  initial begin
    if (DEPTH > (1 << ADDR_W) || DEPTH == 0) begin
      $error("lcdpal_ram depth does not fit the address width");
    end
  end

  // Table write; no reset so the array maps onto plain storage.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data always come out of a register.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// >>> verilog/lcdpal_expand.sv
/*
 Widens a stored 5-6-5 palette entry to 24-bit display data. Colour entries
 fill each component's missing low bits with ones when the stored part is
 nonzero; monochrome entries use only the blue field as the gray level.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
module lcdpal_expand
  import lcdpal_pkg::*;
(
  input wire logic [lcdpal_pkg::LCDPAL_STORE_W-1:0] stored_i,
  input wire logic mono_i,
  output logic [lcdpal_pkg::LCDPAL_ENTRY_W-1:0] pixel_o
);

  logic [4:0] red;
  logic [5:0] grn;
  logic [4:0] blu;

  // Split the stored word into its three components.
  assign red = stored_i[15:11];
  assign grn = stored_i[10:5];
  assign blu = stored_i[4:0];

  // Extend each component to eight bits, or pass gray alone.
  always_comb begin
    if (mono_i) begin
      pixel_o = {16'h0000, blu, {3{|blu}}};
    end else begin
      pixel_o = {red, {3{|red}}, grn, {2{|grn}}, blu, {3{|blu}}};
    end
  end

endmodule

// >>> verilog/lcdpal_top.sv
/*
 Colour palette lookup stage of the display controller. Holds the control
 and frame fetch mode registers, the palette access state machine and the
 pixel lookup path that feeds the display data output.
 Assumes a register master on the same clock that follows the plain strobe
 protocol, and a pixel source on the same clock that presents one palette
 index per cycle with a valid flag.
*/
`timescale 1ns/100ps
module lcdpal_top
  import lcdpal_pkg::*;
#(
  parameter int unsigned ENTRIES = 256
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [lcdpal_pkg::LCDPAL_ADDR_W-1:0] reg_addr_i,
  input wire logic [lcdpal_pkg::LCDPAL_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [lcdpal_pkg::LCDPAL_DATA_W-1:0] reg_rdata_o,
  input wire logic pixel_valid_i,
  input wire logic [lcdpal_pkg::LCDPAL_INDEX_W-1:0] pixel_index_i,
  output logic display_valid_o,
  output logic [lcdpal_pkg::LCDPAL_ENTRY_W-1:0] display_data_out_o
);

  // Only the documented table size is served by the 8-bit index.
  initial begin
    if (ENTRIES != LCDPAL_ENTRIES) begin
      $error("lcdpal_top supports exactly 256 palette entries");
    end
  end

  // Control state.
  lcdpal_state_t state_r;
  lcdpal_state_t state_nxt;
  logic palette_access_enable_r;
  logic palette_access_enable_nxt;
  logic [1:0] drain_cnt_r;
  logic [1:0] drain_cnt_nxt;
  logic palette_access_status;

  // Frame fetch mode register fields.
  logic mono_r;
  logic mono_nxt;
  logic [2:0] fmt_r;
  logic [2:0] fmt_nxt;
  logic [1:0] col_r;
  logic [1:0] col_nxt;
  logic [4:0] burst_r;
  logic [4:0] burst_nxt;
  logic [4:0] burst_max;
  logic burst_fits;

  // Bus decode.
  logic hit_ctrl;
  logic hit_mode;
  logic hit_entry;
  logic [LCDPAL_INDEX_W-1:0] entry_index;
  logic entry_write;

  // Read return path.
  logic [LCDPAL_DATA_W-1:0] reg_rdata_r;
  logic [LCDPAL_DATA_W-1:0] reg_rdata_nxt;
  logic entry_rd_r;
  logic entry_rd_nxt;

  // Table ports.
  logic [LCDPAL_INDEX_W-1:0] ram_rd_addr;
  logic [LCDPAL_STORE_W-1:0] ram_wr_data;
  logic [LCDPAL_STORE_W-1:0] ram_rd_data;
  logic [LCDPAL_ENTRY_W-1:0] entry_view;
  logic [LCDPAL_ENTRY_W-1:0] expanded;

  // Pixel pipe.
  logic pix_valid_r;
  logic pix_valid_nxt;
  logic disp_valid_r;
  logic disp_valid_nxt;
  logic [LCDPAL_ENTRY_W-1:0] disp_data_r;
  logic [LCDPAL_ENTRY_W-1:0] disp_data_nxt;
  logic setting_active;

  // Address decode; misaligned or unmapped addresses hit nothing.
  assign hit_ctrl = (reg_addr_i == LCDPAL_CTRL_OFF);
  assign hit_mode = (reg_addr_i == LCDPAL_MODE_OFF);
  assign hit_entry = (reg_addr_i[11:10] == LCDPAL_ENTRY_PAGE) && (reg_addr_i[1:0] == 2'h0);
  assign entry_index = reg_addr_i[9:2];

  // Entries are only written once the table has been handed over.
  assign entry_write = reg_write_i && hit_entry && palette_access_status;

  // Keep only the stored bits of each component.
  assign ram_wr_data = {reg_wdata_i[LCDPAL_RED_MSB:LCDPAL_RED_LSB],
                        reg_wdata_i[LCDPAL_GRN_MSB:LCDPAL_GRN_LSB],
                        reg_wdata_i[LCDPAL_BLU_MSB:LCDPAL_BLU_LSB]};

  // Status follows the state machine; display is blanked while enabled.
  assign palette_access_status = (state_r == LCDPAL_ST_SETTING);
  assign setting_active = palette_access_enable_r || (state_r != LCDPAL_ST_NORMAL);

  // Software owns the read port while setting, the pixel source otherwise.
  assign ram_rd_addr = palette_access_status ? entry_index : pixel_index_i;

  // Palette table of 256 stored 5-6-5 entries.
  lcdpal_ram #(
    .DEPTH(LCDPAL_ENTRIES),
    .ADDR_W(LCDPAL_INDEX_W),
    .WIDTH(LCDPAL_STORE_W)
  ) u_table (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(entry_write),
    .wr_addr_i(entry_index),
    .wr_data_i(ram_wr_data),
    .rd_addr_i(ram_rd_addr),
    .rd_data_o(ram_rd_data)
  );

  // Widens the looked-up entry for the display.
  lcdpal_expand u_expand (
    .stored_i(ram_rd_data),
    .mono_i(mono_r),
    .pixel_o(expanded)
  );

  // Software reads an entry back with its unstored bits as zero.
  assign entry_view = {ram_rd_data[15:11], 3'h0, ram_rd_data[10:5], 2'h0,
                       ram_rd_data[4:0], 3'h0};

  // Largest burst whose lines stay inside one SDRAM row for a 64x128 frame.
  always_comb begin
    burst_max = LCDPAL_BURST_NONE;
    case (fmt_r)
      LCDPAL_FMT_4BPP_PACKED: begin
        if (col_r == LCDPAL_COL_8) begin
          burst_max = LCDPAL_BURST_16;
        end
      end
      LCDPAL_FMT_4BPP_UNPACKED: begin
        if (col_r == LCDPAL_COL_8) begin
          burst_max = LCDPAL_BURST_8;
        end else if (col_r == LCDPAL_COL_9) begin
          burst_max = LCDPAL_BURST_16;
        end
      end
      LCDPAL_FMT_6BPP: begin
        if (!mono_r) begin
          burst_max = LCDPAL_BURST_NONE;
        end else if (col_r == LCDPAL_COL_8) begin
          burst_max = LCDPAL_BURST_8;
        end else if (col_r == LCDPAL_COL_9) begin
          burst_max = LCDPAL_BURST_16;
        end
      end
      LCDPAL_FMT_8BPP: begin
        if (mono_r) begin
          burst_max = LCDPAL_BURST_NONE;
        end else if (col_r == LCDPAL_COL_8) begin
          burst_max = LCDPAL_BURST_8;
        end else if (col_r == LCDPAL_COL_9) begin
          burst_max = LCDPAL_BURST_16;
        end
      end
      default: begin
        burst_max = LCDPAL_BURST_NONE;
      end
    endcase
  end

  // A zero burst or an unusable combination never fits.
  assign burst_fits = (burst_r != 5'h00) && (burst_r <= burst_max);

  // Palette access state machine and register writes.
  always_comb begin
    state_nxt = state_r;
    drain_cnt_nxt = drain_cnt_r;
    palette_access_enable_nxt = palette_access_enable_r;
    mono_nxt = mono_r;
    fmt_nxt = fmt_r;
    col_nxt = col_r;
    burst_nxt = burst_r;
    if (reg_write_i && hit_ctrl) begin
      palette_access_enable_nxt = reg_wdata_i[LCDPAL_EN_BIT];
    end
    if (reg_write_i && hit_mode) begin
      mono_nxt = reg_wdata_i[LCDPAL_MONO_BIT];
      fmt_nxt = reg_wdata_i[LCDPAL_FMT_LSB +: 3];
      col_nxt = reg_wdata_i[LCDPAL_COL_LSB +: 2];
      burst_nxt = reg_wdata_i[LCDPAL_BURST_LSB +: 5];
    end
    case (state_r)
      LCDPAL_ST_NORMAL: begin
        if (palette_access_enable_r) begin
          state_nxt = LCDPAL_ST_DRAIN;
          drain_cnt_nxt = LCDPAL_DRAIN_CYCLES;
        end
      end
      LCDPAL_ST_DRAIN: begin
        if (!palette_access_enable_r) begin
          state_nxt = LCDPAL_ST_NORMAL;
        end else if (drain_cnt_r == 2'h1) begin
          state_nxt = LCDPAL_ST_SETTING;
        end else begin
          drain_cnt_nxt = drain_cnt_r - 2'h1;
        end
      end
      LCDPAL_ST_SETTING: begin
        if (!palette_access_enable_r) begin
          state_nxt = LCDPAL_ST_NORMAL;
        end
      end
      default: begin
        state_nxt = LCDPAL_ST_NORMAL;
      end
    endcase
  end

  // Control registers take their reset values under reset.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= LCDPAL_ST_NORMAL;
      drain_cnt_r <= 2'h0;
      palette_access_enable_r <= LCDPAL_EN_RST;
      mono_r <= LCDPAL_MONO_RST;
      fmt_r <= LCDPAL_FMT_RST;
      col_r <= LCDPAL_COL_RST;
      burst_r <= LCDPAL_BURST_RST;
    end else begin
      state_r <= state_nxt;
      drain_cnt_r <= drain_cnt_nxt;
      palette_access_enable_r <= palette_access_enable_nxt;
      mono_r <= mono_nxt;
      fmt_r <= fmt_nxt;
      col_r <= col_nxt;
      burst_r <= burst_nxt;
    end
  end

  // Register read data; entry reads are taken from the table next cycle.
  always_comb begin
    reg_rdata_nxt = '0;
    entry_rd_nxt = 1'b0;
    if (reg_read_i) begin
      if (hit_ctrl) begin
        reg_rdata_nxt[LCDPAL_EN_BIT] = palette_access_enable_r;
        reg_rdata_nxt[LCDPAL_STAT_BIT] = palette_access_status;
        reg_rdata_nxt[LCDPAL_FIT_BIT] = burst_fits;
      end else if (hit_mode) begin
        reg_rdata_nxt[LCDPAL_MONO_BIT] = mono_r;
        reg_rdata_nxt[LCDPAL_FMT_LSB +: 3] = fmt_r;
        reg_rdata_nxt[LCDPAL_COL_LSB +: 2] = col_r;
        reg_rdata_nxt[LCDPAL_BURST_LSB +: 5] = burst_r;
      end else if (hit_entry && palette_access_status) begin
        entry_rd_nxt = 1'b1;
      end
    end
  end

  // Read return registers.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_r <= '0;
      entry_rd_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
      entry_rd_r <= entry_rd_nxt;
    end
  end

  // Both sources are flip-flops; the select is registered too.
  assign reg_rdata_o = entry_rd_r ? {8'h00, entry_view} : reg_rdata_r;

  // Pixel pipe: index in cycle 0, table data in cycle 1, display in cycle 2.
  always_comb begin
    pix_valid_nxt = pixel_valid_i && !palette_access_status;
    disp_valid_nxt = pix_valid_r;
    if (setting_active) begin
      disp_data_nxt = '0;
    end else if (pix_valid_r) begin
      disp_data_nxt = expanded;
    end else begin
      disp_data_nxt = disp_data_r;
    end
  end

  // Pixel pipe registers.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pix_valid_r <= 1'b0;
      disp_valid_r <= 1'b0;
      disp_data_r <= '0;
    end else begin
      pix_valid_r <= pix_valid_nxt;
      disp_valid_r <= disp_valid_nxt;
      disp_data_r <= disp_data_nxt;
    end
  end

  assign display_valid_o = disp_valid_r;
  assign display_data_out_o = disp_data_r;

endmodule

// >>> tb/lcdpal_checker.sv
/*
 Port checker for the palette lookup stage, bound to its top module.
 Assumes only the top module ports and a single clock domain.
*/
`timescale 1ns/100ps
module lcdpal_checker
  import lcdpal_pkg::*;
#(
  parameter int unsigned ENTRIES = 256
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [lcdpal_pkg::LCDPAL_ADDR_W-1:0] reg_addr_i,
  input wire logic [lcdpal_pkg::LCDPAL_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [lcdpal_pkg::LCDPAL_DATA_W-1:0] reg_rdata_o,
  input wire logic pixel_valid_i,
  input wire logic [lcdpal_pkg::LCDPAL_INDEX_W-1:0] pixel_index_i,
  input wire logic display_valid_o,
  input wire logic [lcdpal_pkg::LCDPAL_ENTRY_W-1:0] display_data_out_o
);
  import lcdpal_pkg::*;
  logic en_r;
  logic en_nxt;
  logic mono_r;
  logic mono_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Shadows the enable and mono bits and counts cycles spent with enable set.
  always_comb begin
    en_nxt = en_r;
    mono_nxt = mono_r;
    if (reg_write_i && reg_addr_i == LCDPAL_CTRL_OFF) en_nxt = reg_wdata_i[LCDPAL_EN_BIT];
    if (reg_write_i && reg_addr_i == LCDPAL_MODE_OFF) mono_nxt = reg_wdata_i[LCDPAL_MONO_BIT];
    cnt_nxt = !en_r ? 2'h0 : (cnt_r == 2'h3 ? cnt_r : cnt_r + 2'h1);
  end

  // Registers the shadow state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_r <= 1'b0;
      mono_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      en_r <= en_nxt;
      mono_r <= mono_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  chk_reset_quiet: assert property (
    $rose(reset_n_i) |-> !display_valid_o && reg_rdata_o == 32'h0)
    else $error("outputs not quiet after reset");
  chk_ctrl_status: assert property (
    reg_read_i && reg_addr_i == LCDPAL_CTRL_OFF |=>
    reg_rdata_o[1:0] == {$past(cnt_r) == 2'h3, $past(en_r)})
    else $error("control read shows wrong enable or status");
  chk_setting_zero: assert property (
    en_r && $past(en_r) |-> display_data_out_o == 24'h0)
    else $error("display data not zero in setting mode");
  chk_pixel_latency: assert property (
    pixel_valid_i && cnt_r != 2'h3 |-> ##2 display_valid_o)
    else $error("pixel not shown two cycles later");
  chk_no_spurious: assert property (
    display_valid_o |-> $past(pixel_valid_i, 2))
    else $error("display valid without a pixel");
  chk_entry_width: assert property (
    reg_read_i && reg_addr_i[11:10] == LCDPAL_ENTRY_PAGE |=> reg_rdata_o[31:24] == 8'h0)
    else $error("entry read wider than 24 bits");
  chk_unstored_bits: assert property (
    reg_read_i && reg_addr_i[11:10] == LCDPAL_ENTRY_PAGE |=>
    (reg_rdata_o & 32'h00070307) == 32'h0)
    else $error("unstored entry bits read nonzero");
  chk_mono_upper: assert property (
    display_valid_o && mono_r && $past(mono_r, 3) |-> display_data_out_o[23:8] == 16'h0)
    else $error("mono display upper bits nonzero");
endmodule

bind lcdpal_top lcdpal_checker #(.ENTRIES(ENTRIES)) lcdpal_checker_inst (.clk_i, .reset_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .pixel_valid_i,
  .pixel_index_i, .display_valid_o, .display_data_out_o);

// >>> tb/lcdpal_lcd_model.sv
/*
 Display module model: records every pixel word the stage presents.
 Assumes the stage clock and its display valid flag.
*/
`timescale 1ns/100ps
module lcdpal_lcd_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic display_valid_i,
  input wire logic [23:0] data_i
);
  logic [23:0] got[$];

  // Latches each shown pixel at the edge closing its valid cycle.
  always @(posedge clk_i) begin
    if (reset_n_i && display_valid_i) got.push_back(data_i);
  end
endmodule

// >>> tb/tb.sv
/*
 Self-checking bench for the palette lookup stage.
 Assumes the design package, the display model and the bound checker.
*/
`timescale 1ns/100ps
module tb;
  import lcdpal_pkg::*;
  logic clk_i;
  logic reset_n_i;
  logic [11:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_write_i;
  logic reg_read_i;
  logic [31:0] reg_rdata_o;
  logic pixel_valid_i;
  logic [7:0] pixel_index_i;
  logic display_valid_o;
  logic [23:0] display_data_out_o;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] idx_tab[4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  logic [23:0] val_tab[4] = '{24'hffffff, 24'h000700, 24'h8f4b2f, 24'h000000};
  logic [15:0] mode_tab[10] = '{16'h1004, 16'h1104, 16'h0806, 16'h0906, 16'h1016,
                                16'h0809, 16'h0808, 16'h080a, 16'h0803, 16'h0004};
  logic fit_tab[10] = '{1, 0, 1, 0, 1, 1, 0, 1, 0, 0};

  lcdpal_top #(.ENTRIES(256)) lcdpal_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .pixel_valid_i(pixel_valid_i),
    .pixel_index_i(pixel_index_i), .display_valid_o(display_valid_o),
    .display_data_out_o(display_data_out_o));
  lcdpal_lcd_model lcdpal_lcd_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .display_valid_i(display_valid_o), .data_i(display_data_out_o));

  // Free-running 100 ns clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask

  // Widens a 24-bit entry the way the display sees it.
  function automatic logic [23:0] shown(input logic [23:0] v, input logic mono);
    logic [4:0] b;
    b = v[7:3];
    if (mono) shown = {16'h0, b, {3{|b}}};
    else shown = {v[23:19], {3{|v[23:19]}}, v[15:10], {2{|v[15:10]}}, b, {3{|b}}};
  endfunction

  task automatic test_reset();
    logic [31:0] d;
    rd(LCDPAL_CTRL_OFF, d);
    chk("control after reset", 32'h0, d);
    rd(LCDPAL_MODE_OFF, d);
    chk("mode after reset", 32'h0, d);
    rd(12'h008, d);
    chk("unmapped read", 32'h0, d);
    $display("test_reset done");
  endtask

  task automatic test_fill();
    logic [31:0] d;
    int n;
    wr(LCDPAL_CTRL_OFF, 32'h1);
    n = 0;
    do begin
      rd(LCDPAL_CTRL_OFF, d);
      n++;
    end while (d[1] !== 1'b1 && n < 8);
    chk("status after enable", 32'h3, d & 32'h3);
    @(posedge clk_i);
    pixel_valid_i <= 1'b1;
    @(posedge clk_i);
    pixel_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("display in setting mode", 32'h0, {8'h0, display_data_out_o});
    for (int i = 0; i < 4; i++) begin
      wr(12'h400 + {2'h0, idx_tab[i], 2'h0}, {8'h0, val_tab[i]});
      rd(12'h400 + {2'h0, idx_tab[i], 2'h0}, d);
      chk("entry readback", {8'h0, val_tab[i] & 24'hf8fcf8}, d);
    end
    wr(LCDPAL_CTRL_OFF, 32'h0);
    rd(LCDPAL_CTRL_OFF, d);
    chk("control after leave", 32'h0, d);
    $display("test_fill done");
  endtask

  task automatic test_lookup(input logic mono);
    wr(LCDPAL_MODE_OFF, {31'h0, mono});
    lcdpal_lcd_model_inst.got.delete();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      pixel_valid_i <= 1'b1;
      pixel_index_i <= idx_tab[i];
    end
    @(posedge clk_i);
    pixel_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("pixel count", 32'h4, lcdpal_lcd_model_inst.got.size());
    foreach (lcdpal_lcd_model_inst.got[i]) begin
      chk("pixel data", {8'h0, shown(val_tab[i], mono)},
          {8'h0, lcdpal_lcd_model_inst.got[i]});
    end
    $display("test_lookup done");
  endtask

  // Shows a lit pixel, then enters setting mode and expects the output blanked.
  task automatic test_blank();
    logic [31:0] d;
    wr(LCDPAL_MODE_OFF, 32'h0);
    @(posedge clk_i);
    pixel_valid_i <= 1'b1;
    pixel_index_i <= idx_tab[0];
    @(posedge clk_i);
    pixel_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("display before setting", {8'h0, shown(val_tab[0], 1'b0)},
        {8'h0, display_data_out_o});
    wr(LCDPAL_CTRL_OFF, 32'h1);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("display blanked", 32'h0, {8'h0, display_data_out_o});
    wr(LCDPAL_CTRL_OFF, 32'h0);
    rd(LCDPAL_CTRL_OFF, d);
    chk("control after blank", 32'h0, d);
    $display("test_blank done");
  endtask

  // Resets the stage in mid-run while setting mode is on and expects reset values.
  task automatic test_midreset();
    logic [31:0] d;
    wr(LCDPAL_MODE_OFF, 32'h1);
    wr(LCDPAL_CTRL_OFF, 32'h1);
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(LCDPAL_CTRL_OFF, d);
    chk("control after mid reset", 32'h0, d);
    rd(LCDPAL_MODE_OFF, d);
    chk("mode after mid reset", 32'h0, d);
    $display("test_midreset done");
  endtask

  task automatic test_burst();
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      wr(LCDPAL_MODE_OFF, {16'h0, mode_tab[i]});
      rd(LCDPAL_CTRL_OFF, d);
      chk("burst fits", {31'h0, fit_tab[i]}, {31'h0, d[LCDPAL_FIT_BIT]});
    end
    $display("test_burst done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence.
  initial begin
    reset_n_i = 1'b0;
    reg_addr_i = 12'h0;
    reg_wdata_i = 32'h0;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    pixel_valid_i = 1'b0;
    pixel_index_i = 8'h0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    test_fill();
    test_lookup(1'b0);
    test_blank();
    test_lookup(1'b1);
    test_burst();
    test_midreset();
    complete_run();
  end

  // Cuts a hang short well beyond the roughly 150 cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
endmodule
